// ### common/prds_pkg.sv
// Constants and carrier types for the reset-default pin selector.
// Assumes one core clock; all pad enables are active low.
package prds_pkg;

  // ==========================================================
  // Pin group widths
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int STROBE_W = 4;
  localparam int SIZE_W = 2;
  localparam int CS_W = 7;
  localparam int ACK_W = 2;
  localparam int DBG_W = 4;
  localparam int OTHER_W = 16;

  // ==========================================================
  // Bus output function group (address plus bus control)
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [STROBE_W-1:0] byte_lane_strobes;
    logic output_enable;
    logic read_write;
    logic [SIZE_W-1:0] transfer_size_code;
    logic transfer_start_strobe;
    logic transfer_in_progress;
    logic [CS_W-1:0] chip_select;
  } prds_bus_out_t;

  localparam int BUS_OUT_W = $bits(prds_bus_out_t);
  localparam int BUS_CTRL_W = BUS_OUT_W - ADDR_W;

  // Bus pin vector layout: outputs, then data, then acknowledges
  localparam int DATA_LSB = BUS_OUT_W;
  localparam int ACK_LSB = BUS_OUT_W + DATA_W;
  localparam int BUS_PIN_W = BUS_OUT_W + DATA_W + ACK_W;

  // Debug output function group
  typedef struct packed {
    logic [DBG_W-1:0] debug_data_out;
    logic [DBG_W-1:0] processor_status_out;
  } prds_dbg_t;

  localparam int DBG_OUT_W = $bits(prds_dbg_t);

  // ==========================================================
  // Boot modes
  typedef enum logic {
    BOOT_SINGLE = 1'b0,
    BOOT_EXT = 1'b1
  } prds_boot_t;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
  localparam logic [BUS_CTRL_W-1:0] CTRL_IDLE = 17'h1_ffff;
  localparam logic [BUS_OUT_W-1:0] BUS_IDLE = {ADDR_RST, CTRL_IDLE};
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [ACK_W-1:0] ACK_RST = 2'h3;
  localparam logic [DBG_OUT_W-1:0] DBG_RST = 8'h00;
  localparam logic RST_OUT_RST = 1'b0;
  localparam logic SER_OUT_RST = 1'b1;
  localparam logic [BUS_PIN_W-1:0] ALL_IN_N = {BUS_PIN_W{1'b1}};
  localparam logic [BUS_PIN_W-1:0] EXT_RST_OE_N =
    {{ACK_W{1'b1}}, {DATA_W{1'b1}}, {BUS_OUT_W{1'b0}}};
  localparam logic [OTHER_W-1:0] OTHER_IN_N = 16'hffff;
  localparam logic [OTHER_W-1:0] OTHER_RST = 16'h0000;

endpackage

// ### design/prds_pad_mux.sv
// Registered pad cell group: function or GPIO, with reset defaults.
// Assumes synchronous reset; reset value and enable come from the parent.
module prds_pad_mux #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sel_func,
  input wire logic force_in,
  input wire logic [W-1:0] rst_val,
  input wire logic [W-1:0] rst_oe_n,
  input wire logic [W-1:0] func_out,
  input wire logic [W-1:0] func_oe_n,
  input wire logic [W-1:0] gpio_out,
  input wire logic [W-1:0] gpio_oe_n,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe_n
);

  // ==========================================================
  // Output level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pad_out <= rst_val;
    end else if (sel_func) begin
      pad_out <= func_out;
    end else begin
      pad_out <= gpio_out;
    end
  end

  // Drive enable; GPIO held as input until configured
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pad_oe_n <= rst_oe_n;
    end else if (sel_func) begin
      pad_oe_n <= func_oe_n;
    end else if (force_in) begin
      pad_oe_n <= {W{1'b1}};
    end else begin
      pad_oe_n <= gpio_oe_n;
    end
  end

endmodule

// ### design/pin_reset_default_select.sv
// Reset-default function selection for the multiplexed device pins.
// Assumes pins are synchronous to core_clk and the boot strap is stable
// while sys_rst is high.
module pin_reset_default_select
  import prds_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic boot_ext_strap,
  input wire logic pin_cfg_load,
  input wire logic reset_input_pin_n,
  input wire logic reset_out_req_n,
  input wire logic clk_out_src,
  input wire logic xtal_drive_src,
  input wire logic jtag_enable_pin,
  input wire logic debug_serial_clock_trst_pin,
  input wire logic breakpoint_request_tms_pin,
  input wire logic dsi_tdi_pin,
  input wire logic serial_out_src,
  input wire logic tap_data_out_src,
  input wire prds_pkg::prds_dbg_t dbg_func,
  input wire prds_pkg::prds_bus_out_t bus_func,
  input wire logic [prds_pkg::DATA_W-1:0] data_func_out,
  input wire logic data_func_oe_n,
  input wire logic [prds_pkg::BUS_PIN_W-1:0] bus_gpio_out,
  input wire logic [prds_pkg::BUS_PIN_W-1:0] bus_gpio_oe_n,
  input wire logic [prds_pkg::OTHER_W-1:0] other_gpio_out,
  input wire logic [prds_pkg::OTHER_W-1:0] other_gpio_oe_n,
  input wire logic [prds_pkg::BUS_PIN_W-1:0] bus_pad_in,
  input wire logic [prds_pkg::OTHER_W-1:0] other_pad_in,
  output logic [prds_pkg::BUS_PIN_W-1:0] bus_pad_out,
  output logic [prds_pkg::BUS_PIN_W-1:0] bus_pad_oe_n,
  output logic [prds_pkg::OTHER_W-1:0] other_pad_out,
  output logic [prds_pkg::OTHER_W-1:0] other_pad_oe_n,
  output logic [prds_pkg::BUS_PIN_W-1:0] bus_gpio_in,
  output logic [prds_pkg::OTHER_W-1:0] other_gpio_in,
  output logic [prds_pkg::DATA_W-1:0] bus_data_in,
  output logic transfer_acknowledge_n,
  output logic transfer_error_acknowledge_n,
  output logic ext_boot_active,
  output logic core_reset_in_n,
  output logic reset_output_pin,
  output logic system_clock_output,
  output logic xtal_output,
  output logic debug_serial_out,
  output prds_pkg::prds_dbg_t debug_pad_out,
  output logic debug_serial_clock,
  output logic breakpoint_request,
  output logic debug_serial_in,
  output logic tap_reset,
  output logic tap_mode_select,
  output logic tap_data_in
);
  import prds_pkg::*;

  prds_boot_t mode_reg;
  logic dflt_reg;
  logic dbg_out_en_reg;
  logic ext_sel;
  logic [BUS_PIN_W-1:0] bus_func_out;
  logic [BUS_PIN_W-1:0] bus_func_oe_n;
  logic [BUS_PIN_W-1:0] bus_rst_oe_n;
  logic [BUS_PIN_W-1:0] bus_rst_val;

  // ==========================================================
  // Boot mode and default hold

  // Strap caught on every reset cycle, kept after release
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_reg <= prds_boot_t'(boot_ext_strap);
    end
  end

  // GPIO stays input until pin assignment is loaded
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      dflt_reg <= 1'b1;
    end else if (pin_cfg_load) begin
      dflt_reg <= 1'b0;
    end
  end

  assign ext_sel = (mode_reg == BOOT_EXT);
  assign ext_boot_active = ext_sel;

  // ==========================================================
  // Bus pin group

  // Function side: outputs driven, data by bus, acks always in
  assign bus_func_out = {ACK_RST, data_func_out, bus_func};
  assign bus_func_oe_n = {{ACK_W{1'b1}}, {DATA_W{data_func_oe_n}},
                          {BUS_OUT_W{1'b0}}};
  assign bus_rst_val = {ACK_RST, DATA_RST, BUS_IDLE};
  // Single-chip reset leaves every bus pin an input
  assign bus_rst_oe_n = ext_sel ? EXT_RST_OE_N : ALL_IN_N;

  prds_pad_mux #(
    .W(BUS_PIN_W)
  ) u_bus_pads (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sel_func(ext_sel),
    .force_in(dflt_reg),
    .rst_val(bus_rst_val),
    .rst_oe_n(bus_rst_oe_n),
    .func_out(bus_func_out),
    .func_oe_n(bus_func_oe_n),
    .gpio_out(bus_gpio_out),
    .gpio_oe_n(bus_gpio_oe_n),
    .pad_out(bus_pad_out),
    .pad_oe_n(bus_pad_oe_n)
  );

  // Inputs fan to both bus controller and GPIO
  assign bus_gpio_in = bus_pad_in;
  assign bus_data_in = bus_pad_in[ACK_LSB-1:DATA_LSB];
  assign transfer_acknowledge_n = bus_pad_in[ACK_LSB];
  assign transfer_error_acknowledge_n = bus_pad_in[ACK_LSB+1];

  // ==========================================================
  // Remaining GPIO-capable pins, GPIO in every mode
  prds_pad_mux #(
    .W(OTHER_W)
  ) u_other_pads (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sel_func(1'b0),
    .force_in(dflt_reg),
    .rst_val(OTHER_RST),
    .rst_oe_n(OTHER_IN_N),
    .func_out(OTHER_RST),
    .func_oe_n(OTHER_IN_N),
    .gpio_out(other_gpio_out),
    .gpio_oe_n(other_gpio_oe_n),
    .pad_out(other_pad_out),
    .pad_oe_n(other_pad_oe_n)
  );

  assign other_gpio_in = other_pad_in;

  // ==========================================================
  // Clock, reset and debug dedicated pins

  // Reset output held low, serial out high during reset
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reset_output_pin <= RST_OUT_RST;
      debug_serial_out <= SER_OUT_RST;
    end else begin
      reset_output_pin <= reset_out_req_n;
      debug_serial_out <= jtag_enable_pin ? tap_data_out_src
                                          : serial_out_src;
    end
  end

  // Debug data and status always driven: DBG_RST during reset, debug function after
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      debug_pad_out <= DBG_RST;
      dbg_out_en_reg <= 1'b1;
    end else begin
      debug_pad_out <= dbg_func;
      dbg_out_en_reg <= 1'b1;
    end
  end

  // Clock and crystal outputs pass straight through
  assign system_clock_output = clk_out_src;
  assign xtal_output = xtal_drive_src;

  // Input-only pins; no drive path exists for them
  assign core_reset_in_n = reset_input_pin_n;

  // Shared debug pins routed by JTAG enable
  assign tap_reset = jtag_enable_pin & debug_serial_clock_trst_pin;
  assign tap_mode_select = jtag_enable_pin & breakpoint_request_tms_pin;
  assign tap_data_in = jtag_enable_pin & dsi_tdi_pin;
  assign debug_serial_clock = ~jtag_enable_pin & debug_serial_clock_trst_pin;
  assign breakpoint_request = ~jtag_enable_pin & breakpoint_request_tms_pin;
  assign debug_serial_in = ~jtag_enable_pin & dsi_tdi_pin;

  // ==========================================================
  // Checks

  property p_single_in;
    @(posedge core_clk) disable iff (sys_rst)
    (!ext_sel && dflt_reg) |-> (&bus_pad_oe_n && &other_pad_oe_n);
  endproperty
  a_single_in: assert property (p_single_in)
    else $error("single-chip pin driven before configuration");

  property p_gpio_follow;
    @(posedge core_clk) disable iff (sys_rst)
    (!dflt_reg && !pin_cfg_load) |=>
      (other_pad_oe_n == $past(other_gpio_oe_n));
  endproperty
  a_gpio_follow: assert property (p_gpio_follow)
    else $error("gpio direction not applied");

  property p_reset_outs;
    @(posedge core_clk) sys_rst[*2] |->
      (reset_output_pin == 1'b0 && debug_serial_out == 1'b1 &&
       debug_pad_out == DBG_RST && dbg_out_en_reg);
  endproperty
  a_reset_outs: assert property (p_reset_outs)
    else $error("reset output levels wrong");

  property p_dbg_inputs;
    @(posedge core_clk) !jtag_enable_pin |->
      (debug_serial_clock == debug_serial_clock_trst_pin && !tap_reset &&
       breakpoint_request == breakpoint_request_tms_pin);
  endproperty
  a_dbg_inputs: assert property (p_dbg_inputs)
    else $error("debug input misrouted");

  property p_ext_bus;
    @(posedge core_clk) disable iff (sys_rst)
    ext_sel ##1 !sys_rst |->
      (bus_pad_out[BUS_OUT_W-1:0] == $past(bus_func) &&
       bus_pad_oe_n[BUS_OUT_W-1:0] == '0);
  endproperty
  a_ext_bus: assert property (p_ext_bus)
    else $error("bus pins not in bus role");

  property p_ext_other;
    @(posedge core_clk) disable iff (sys_rst)
    (ext_sel && dflt_reg) |-> &other_pad_oe_n;
  endproperty
  a_ext_other: assert property (p_ext_other)
    else $error("non-bus pin driven in external boot");

  property p_ext_reset;
    @(posedge core_clk) (sys_rst && ext_sel) |=>
      (bus_pad_out[BUS_CTRL_W-1:0] == CTRL_IDLE &&
       bus_pad_oe_n == EXT_RST_OE_N);
  endproperty
  a_ext_reset: assert property (p_ext_reset)
    else $error("external boot reset levels wrong");

  property p_single_gpio;
    @(posedge core_clk) disable iff (sys_rst)
    (!ext_sel && !dflt_reg) |=>
      (bus_pad_out == $past(bus_gpio_out));
  endproperty
  a_single_gpio: assert property (p_single_gpio)
    else $error("address or data pin not gpio");

  property p_jtag_route;
    @(posedge core_clk) jtag_enable_pin |->
      (tap_reset == debug_serial_clock_trst_pin && tap_data_in == dsi_tdi_pin &&
       !debug_serial_in);
  endproperty
  a_jtag_route: assert property (p_jtag_route)
    else $error("tap pins misrouted");

endmodule

// ### tb/prds_ext_host.sv
// Far-side model: external memory on the device bus pins, pull-ups on the other pins.
// Assumes pull-ups on every pad; drives data on command and acknowledges always.
module prds_ext_host
  import prds_pkg::*;
(
  input wire logic [prds_pkg::BUS_PIN_W-1:0] bus_pad_out,
  input wire logic [prds_pkg::BUS_PIN_W-1:0] bus_pad_oe_n,
  input wire logic [prds_pkg::OTHER_W-1:0] other_pad_out,
  input wire logic [prds_pkg::OTHER_W-1:0] other_pad_oe_n,
  input wire logic mem_drive,
  input wire logic [prds_pkg::DATA_W-1:0] mem_data,
  input wire logic [prds_pkg::ACK_W-1:0] ack_n,
  output logic [prds_pkg::BUS_PIN_W-1:0] bus_pad_in,
  output logic [prds_pkg::OTHER_W-1:0] other_pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [BUS_PIN_W-1:0] far_val;
  logic [BUS_PIN_W-1:0] far_en;
  // ==========================================================
  // Far side: data on command, acknowledges always driven
  assign far_val = {ack_n, mem_data, {BUS_OUT_W{1'b1}}};
  assign far_en = {{ACK_W{1'b1}}, {DATA_W{mem_drive}}, {BUS_OUT_W{1'b0}}};
  // Wire level: device first, then far side, else pull-up
  always_comb begin
    for (int i = 0; i < BUS_PIN_W; i++) begin
      if (!bus_pad_oe_n[i])
        bus_pad_in[i] = bus_pad_out[i];
      else if (far_en[i])
        bus_pad_in[i] = far_val[i];
      else
        bus_pad_in[i] = 1'b1;
    end
  end
  // Other pins: driven level, else pull-up
  assign other_pad_in = other_pad_out | other_pad_oe_n;
endmodule

// ### tb/test_pin_reset_default_select.sv
// Self-checking bench for the reset-default pin selector.
// Assumes the far-side model resolves pad levels; inputs move at negedge.
module test_pin_reset_default_select;
  timeunit 1ns;
  timeprecision 1ns;
  import prds_pkg::*;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    bad_count++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
    $time, (a), (b)); end end
  logic core_clk = 1'b0;
  logic sys_rst, boot_ext_strap, pin_cfg_load, reset_input_pin_n;
  logic reset_out_req_n, clk_out_src, xtal_drive_src, jtag_enable_pin;
  logic debug_serial_clock_trst_pin, breakpoint_request_tms_pin, dsi_tdi_pin, serial_out_src;
  logic tap_data_out_src, data_func_oe_n, mem_drive;
  prds_dbg_t dbg_func, debug_pad_out;
  prds_bus_out_t bus_func;
  logic [DATA_W-1:0] data_func_out, mem_data, bus_data_in;
  logic [ACK_W-1:0] ack_n;
  logic [BUS_PIN_W-1:0] bus_gpio_out, bus_gpio_oe_n, bus_pad_in;
  logic [BUS_PIN_W-1:0] bus_pad_out, bus_pad_oe_n, bus_gpio_in;
  logic [OTHER_W-1:0] other_gpio_out, other_gpio_oe_n, other_pad_in;
  logic [OTHER_W-1:0] other_pad_out, other_pad_oe_n, other_gpio_in;
  logic transfer_acknowledge_n, transfer_error_acknowledge_n;
  logic ext_boot_active, core_reset_in_n, reset_output_pin;
  logic system_clock_output, xtal_output, debug_serial_out;
  logic debug_serial_clock, breakpoint_request, debug_serial_in;
  logic tap_reset, tap_mode_select, tap_data_in;
  int bad_count = 0;
  int cmp_count = 0;

  pin_reset_default_select DUT (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .boot_ext_strap(boot_ext_strap),
    .pin_cfg_load(pin_cfg_load),
    .reset_input_pin_n(reset_input_pin_n),
    .reset_out_req_n(reset_out_req_n),
    .clk_out_src(clk_out_src),
    .xtal_drive_src(xtal_drive_src),
    .jtag_enable_pin(jtag_enable_pin),
    .debug_serial_clock_trst_pin(debug_serial_clock_trst_pin),
    .breakpoint_request_tms_pin(breakpoint_request_tms_pin),
    .dsi_tdi_pin(dsi_tdi_pin),
    .serial_out_src(serial_out_src),
    .tap_data_out_src(tap_data_out_src),
    .dbg_func(dbg_func),
    .bus_func(bus_func),
    .data_func_out(data_func_out),
    .data_func_oe_n(data_func_oe_n),
    .bus_gpio_out(bus_gpio_out),
    .bus_gpio_oe_n(bus_gpio_oe_n),
    .other_gpio_out(other_gpio_out),
    .other_gpio_oe_n(other_gpio_oe_n),
    .bus_pad_in(bus_pad_in),
    .other_pad_in(other_pad_in),
    .bus_pad_out(bus_pad_out),
    .bus_pad_oe_n(bus_pad_oe_n),
    .other_pad_out(other_pad_out),
    .other_pad_oe_n(other_pad_oe_n),
    .bus_gpio_in(bus_gpio_in),
    .other_gpio_in(other_gpio_in),
    .bus_data_in(bus_data_in),
    .transfer_acknowledge_n(transfer_acknowledge_n),
    .transfer_error_acknowledge_n(transfer_error_acknowledge_n),
    .ext_boot_active(ext_boot_active),
    .core_reset_in_n(core_reset_in_n),
    .reset_output_pin(reset_output_pin),
    .system_clock_output(system_clock_output),
    .xtal_output(xtal_output),
    .debug_serial_out(debug_serial_out),
    .debug_pad_out(debug_pad_out),
    .debug_serial_clock(debug_serial_clock),
    .breakpoint_request(breakpoint_request),
    .debug_serial_in(debug_serial_in),
    .tap_reset(tap_reset),
    .tap_mode_select(tap_mode_select),
    .tap_data_in(tap_data_in)
  );

  // Far-side pads: memory data, acknowledges and pull-ups
  prds_ext_host far_side (
    .bus_pad_out(bus_pad_out),
    .bus_pad_oe_n(bus_pad_oe_n),
    .other_pad_out(other_pad_out),
    .other_pad_oe_n(other_pad_oe_n),
    .mem_drive(mem_drive),
    .mem_data(mem_data),
    .ack_n(ack_n),
    .bus_pad_in(bus_pad_in),
    .other_pad_in(other_pad_in)
  );

  // ==========================================================
  // Clock and shared tasks
  always #10 core_clk = ~core_clk;

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Reset for 20 cycles with the given boot strap
  task automatic do_reset(input logic ext);
    @(negedge core_clk);
    sys_rst = 1'b1;
    boot_ext_strap = ext;
    repeat (20) @(negedge core_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_single;
    do_reset(1'b0);
    `CHK(bus_pad_oe_n, ALL_IN_N)
    `CHK(other_pad_oe_n, OTHER_IN_N)
    `CHK(reset_output_pin, RST_OUT_RST)
    `CHK(debug_serial_out, SER_OUT_RST)
    `CHK(ext_boot_active, 1'b0)
    sys_rst = 1'b0;
    repeat (3) @(negedge core_clk);
    `CHK(bus_pad_oe_n, ALL_IN_N)
    `CHK(bus_data_in, mem_data)
    `CHK(other_gpio_in, 16'hffff)
    `CHK(reset_output_pin, reset_out_req_n)
    `CHK(debug_pad_out, dbg_func)
    mem_drive = 1'b0;
    pin_cfg_load = 1'b1;
    @(negedge core_clk);
    pin_cfg_load = 1'b0;
    @(negedge core_clk);
    `CHK(bus_pad_oe_n, bus_gpio_oe_n)
    `CHK(bus_pad_out, bus_gpio_out)
    `CHK(bus_gpio_in, bus_gpio_out | bus_gpio_oe_n)
    `CHK(other_pad_out, other_gpio_out)
    `CHK(other_pad_oe_n, other_gpio_oe_n)
    $display("test single done");
  endtask

  task automatic test_ext;
    mem_drive = 1'b1;
    ack_n = 2'h2;
    do_reset(1'b1);
    `CHK(bus_pad_oe_n, EXT_RST_OE_N)
    `CHK(bus_pad_out[BUS_OUT_W-1:0], BUS_IDLE)
    `CHK(other_pad_oe_n, OTHER_IN_N)
    `CHK(ext_boot_active, 1'b1)
    `CHK(transfer_acknowledge_n, 1'b0)
    `CHK(transfer_error_acknowledge_n, 1'b1)
    `CHK(bus_data_in, mem_data)
    sys_rst = 1'b0;
    bus_func = 41'h0a5_5a3c_0f0f;
    repeat (2) @(negedge core_clk);
    `CHK(bus_pad_out[BUS_OUT_W-1:0], bus_func)
    `CHK(other_pad_oe_n, OTHER_IN_N)
    mem_drive = 1'b0;
    data_func_oe_n = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(bus_pad_out[ACK_LSB-1:DATA_LSB], data_func_out)
    `CHK(bus_pad_oe_n[ACK_LSB-1:DATA_LSB], 32'h0000_0000)
    $display("test ext done");
  endtask

  task automatic test_debug;
    for (int j = 0; j < 2; j++) begin
      jtag_enable_pin = j[0];
      reset_input_pin_n = j[0];
      clk_out_src = j[0];
      xtal_drive_src = !j[0];
      repeat (2) @(negedge core_clk);
      `CHK(tap_reset, j[0])
      `CHK(tap_mode_select, j[0])
      `CHK(tap_data_in, j[0])
      `CHK(debug_serial_clock, !j[0])
      `CHK(breakpoint_request, !j[0])
      `CHK(debug_serial_in, !j[0])
      `CHK(debug_serial_out, j[0])
      `CHK(core_reset_in_n, j[0])
      `CHK(system_clock_output, j[0])
      `CHK(xtal_output, !j[0])
    end
    $display("test debug done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    boot_ext_strap = 1'b0;
    pin_cfg_load = 1'b0;
    reset_input_pin_n = 1'b1;
    reset_out_req_n = 1'b1;
    clk_out_src = 1'b0;
    xtal_drive_src = 1'b0;
    jtag_enable_pin = 1'b0;
    debug_serial_clock_trst_pin = 1'b1;
    breakpoint_request_tms_pin = 1'b1;
    dsi_tdi_pin = 1'b1;
    serial_out_src = 1'b0;
    tap_data_out_src = 1'b1;
    dbg_func = 8'h5c;
    bus_func = 41'h000_0000_0000;
    data_func_out = 32'hc3a5_0f96;
    data_func_oe_n = 1'b1;
    bus_gpio_out = 75'h2a_5a5a_c3c3_0f0f_3cf1;
    bus_gpio_oe_n = 75'h00_0000_0000_ffff_0000;
    other_gpio_out = 16'ha55a;
    other_gpio_oe_n = 16'h00ff;
    mem_drive = 1'b1;
    mem_data = 32'h1234_abcd;
    ack_n = 2'h3;
    repeat (20) @(negedge core_clk);
    test_single();
    test_ext();
    test_debug();
    summarize();
  end
endmodule
